//--- core/sxs_alu_pkg.sv
// Purpose: constants and types for the subtract/xor/swap execution datapath
// Assumes: operations arrive one per clock from the instruction decoder
// Notes:   one op per clock; results register on the next edge
// Function
// - literal minus accumulator into accumulator
// - carry/half-carry set when accumulator not greater
// - register minus accumulator, carry, half-carry, zero
// - destination bit 0 writes accumulator
// - destination bit 1 writes file register
// - direction load copies accumulator, port 5-7
// - subtract with borrow uses inverted carry
// - xor literal into accumulator, zero only
// - nibble exchange, no flags changed
// - xor register, destination routed, zero only
package sxs_alu_pkg;

  localparam int         DATA_W     = 8;
  localparam int         ADDR_W     = 7;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'hff;
  localparam logic [6:0] PORT_A_SEL = 7'h05;
  localparam logic [6:0] PORT_B_SEL = 7'h06;
  localparam logic [6:0] PORT_C_SEL = 7'h07;
  localparam int         NIB_LO_MSB = 3;
  localparam int         NIB_HI_LSB = 4;

  typedef enum logic [2:0]
  {
    SXS_OP_NONE       = 3'b000,
    SXS_OP_LIT_SUB    = 3'b001,
    SXS_OP_REG_SUB    = 3'b010,
    SXS_OP_REG_SUBB   = 3'b011,
    SXS_OP_XOR_LIT    = 3'b100,
    SXS_OP_XOR_REG    = 3'b101,
    SXS_OP_NIB_SWAP   = 3'b110,
    SXS_OP_DIR_LOAD   = 3'b111
  } sxs_op_t;

  typedef struct packed
  {
    logic                valid;
    sxs_op_t             op;
    logic                dest;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   operand;
  } sxs_req_t;

  typedef struct packed
  {
    logic                carry;
    logic                half_carry;
    logic                zero;
  } sxs_flags_t;

  typedef struct packed
  {
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } sxs_fwr_t;

  typedef struct packed
  {
    logic [DATA_W-1:0]   port_a_direction;
    logic [DATA_W-1:0]   port_b_direction;
    logic [DATA_W-1:0]   port_c_direction;
  } sxs_dir_t;

endpackage

//--- core/sxs_alu.sv
// Purpose: execution datapath for subtract, xor, nibble exchange and direction load
// Assumes: REQ_I.operand holds the literal or the addressed file register value
// Notes:   results and flags appear one clock after the request
`timescale 1ns/100ps
module sxs_alu
(
  input  wire logic                   MCLK_I,
  input  wire logic                   RESET_N_I,
  input  wire sxs_alu_pkg::sxs_req_t  REQ_I,
  output logic [7:0]                  ACC_O,
  output sxs_alu_pkg::sxs_flags_t     FLAGS_O,
  output sxs_alu_pkg::sxs_fwr_t       FILE_WR_O,
  output sxs_alu_pkg::sxs_dir_t       DIR_O
);
  import sxs_alu_pkg::*;

  logic [7:0] acc_q;
  logic [7:0] acc_d;
  sxs_flags_t flags_q;
  sxs_flags_t flags_d;
  sxs_fwr_t   fwr_q;
  sxs_fwr_t   fwr_d;
  sxs_dir_t   dir_q;
  sxs_dir_t   dir_d;
  logic [9:0] sub_r;
  logic [7:0] res;
  logic       use_dest;

  // minuend - subtrahend - borrow; carry out means no borrow
  function automatic logic [9:0] sub_calc(input logic [7:0] m, input logic [7:0] s,
                                          input logic b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, m} + {1'b0, ~s} + 9'h001 - {8'h00, b};
    low  = {1'b0, m[NIB_LO_MSB:0]} + {1'b0, ~s[NIB_LO_MSB:0]} + 5'h01 - {4'h0, b};
    sub_calc = {full[8], low[4], full[7:0]};
  endfunction

  // carry and half-carry come only from the subtract group
  function automatic logic is_sub_op(input sxs_op_t op);
    is_sub_op = (op == SXS_OP_LIT_SUB) || (op == SXS_OP_REG_SUB) ||
                (op == SXS_OP_REG_SUBB);
  endfunction

  // zero follows the result for subtracts and both xor forms
  function automatic logic sets_zero(input sxs_op_t op);
    sets_zero = is_sub_op(op) || (op == SXS_OP_XOR_LIT) || (op == SXS_OP_XOR_REG);
  endfunction

  // register-operand forms route their result by the destination bit
  function automatic logic routes_dest(input sxs_op_t op);
    routes_dest = (op == SXS_OP_REG_SUB) || (op == SXS_OP_REG_SUBB) ||
                  (op == SXS_OP_XOR_REG) || (op == SXS_OP_NIB_SWAP);
  endfunction

  // literal forms always land in the accumulator, register forms when dest is 0
  function automatic logic writes_acc(input sxs_op_t op, input logic dest);
    writes_acc = (op == SXS_OP_LIT_SUB) || (op == SXS_OP_XOR_LIT) ||
                 (routes_dest(op) && !dest);
  endfunction

  // shared result of the request on REQ_I; holds no state of its own
  always_comb
  begin
    sub_r    = 10'h000;
    res      = 8'h00;
    use_dest = 1'b0;
    if (REQ_I.valid)
    begin
      use_dest = routes_dest(REQ_I.op);
      case (REQ_I.op)
        SXS_OP_LIT_SUB:
        begin
          sub_r = sub_calc(REQ_I.operand, acc_q, 1'b0);
          res   = sub_r[7:0];
        end
        SXS_OP_REG_SUB:
        begin
          sub_r = sub_calc(REQ_I.operand, acc_q, 1'b0);
          res   = sub_r[7:0];
        end
        SXS_OP_REG_SUBB:
        begin
          sub_r = sub_calc(REQ_I.operand, acc_q, ~flags_q.carry);
          res   = sub_r[7:0];
        end
        SXS_OP_XOR_LIT:
        begin
          res = acc_q ^ REQ_I.operand;
        end
        SXS_OP_XOR_REG:
        begin
          res = acc_q ^ REQ_I.operand;
        end
        SXS_OP_NIB_SWAP:
        begin
          res = {REQ_I.operand[NIB_LO_MSB:0], REQ_I.operand[7:NIB_HI_LSB]};
        end
        default:
        begin
          res = 8'h00;
        end
      endcase
    end
  end

  // accumulator; direction load and writes to file leave it alone
  always_comb
  begin
    acc_d = acc_q;
    if (REQ_I.valid && writes_acc(REQ_I.op, REQ_I.dest))
    begin
      acc_d = res;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      acc_q <= ACC_RST;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  // status flags; only the subtract and xor groups touch them
  always_comb
  begin
    flags_d = flags_q;
    if (REQ_I.valid)
    begin
      if (is_sub_op(REQ_I.op))
      begin
        flags_d.carry      = sub_r[9];
        flags_d.half_carry = sub_r[8];
      end
      if (sets_zero(REQ_I.op))
      begin
        flags_d.zero = (res == 8'h00);
      end
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      flags_q <= '0;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  always_comb
  begin
    fwr_d = '0;
    if (use_dest && REQ_I.dest)
    begin
      fwr_d.we   = 1'b1;
      fwr_d.addr = REQ_I.addr;
      fwr_d.data = res;
    end
  end

  // write strobe is a one-cycle pulse since fwr_d idles at zero
  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      fwr_q <= '0;
    end
    else
    begin
      fwr_q <= fwr_d;
    end
  end

  always_comb
  begin
    dir_d = dir_q;
    if (REQ_I.valid && REQ_I.op == SXS_OP_DIR_LOAD)
    begin
      if (REQ_I.addr == PORT_A_SEL)
      begin
        dir_d.port_a_direction = acc_q;
      end
      else if (REQ_I.addr == PORT_B_SEL)
      begin
        dir_d.port_b_direction = acc_q;
      end
      else if (REQ_I.addr == PORT_C_SEL)
      begin
        dir_d.port_c_direction = acc_q;
      end
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      dir_q <= {DIR_RST, DIR_RST, DIR_RST};
    end
    else
    begin
      dir_q <= dir_d;
    end
  end

  assign ACC_O     = acc_q;
  assign FLAGS_O   = flags_q;
  assign FILE_WR_O = fwr_q;
  assign DIR_O     = dir_q;

endmodule

//--- dv/sxs_alu_properties.sv
// Purpose: port assertions for sxs_alu
// Assumes: results one cycle after the taking edge
// Notes:   bound at foot
`timescale 1ns/100ps
module sxs_alu_properties
(
  input wire logic                    MCLK_I,
  input wire logic                    RESET_N_I,
  input wire sxs_alu_pkg::sxs_req_t   REQ_I,
  input wire logic [7:0]              ACC_O,
  input wire sxs_alu_pkg::sxs_flags_t FLAGS_O,
  input wire sxs_alu_pkg::sxs_fwr_t   FILE_WR_O,
  input wire sxs_alu_pkg::sxs_dir_t   DIR_O
);
  import sxs_alu_pkg::*;
  logic [7:0] a_q;
  logic [7:0] k_q;
  sxs_op_t    op;
  wire logic  d = REQ_I.dest;
  assign op = REQ_I.valid ? REQ_I.op : SXS_OP_NONE;
  always_ff @(posedge MCLK_I) a_q <= ACC_O;
  always_ff @(posedge MCLK_I) k_q <= REQ_I.operand;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  lit_sub_a: assert property (op == SXS_OP_LIT_SUB |=> ACC_O == k_q - a_q)
    else $error("lit sub");
  sub_flags_a: assert property (op inside {SXS_OP_LIT_SUB, SXS_OP_REG_SUB}
    |=> FLAGS_O[2:1] == {a_q <= k_q, a_q[3:0] <= k_q[3:0]}) else $error("sub flags");
  sub_acc_a: assert property (op == SXS_OP_REG_SUB && !d
    |=> ACC_O == k_q - a_q && !FILE_WR_O.we) else $error("sub acc");
  sub_back_a: assert property (op == SXS_OP_REG_SUB && d
    |=> FILE_WR_O.we && FILE_WR_O.data == k_q - a_q && $stable(ACC_O)) else $error("sub back");
  dir_b_a: assert property (op == SXS_OP_DIR_LOAD && REQ_I.addr == PORT_B_SEL
    |=> DIR_O.port_b_direction == a_q && $stable(FLAGS_O)) else $error("dir load");
  sub_borrow_a: assert property (op == SXS_OP_REG_SUBB && !d
    |=> ACC_O == k_q - a_q - {7'h00, ~$past(FLAGS_O.carry)}) else $error("borrow");
  xor_lit_a: assert property (op == SXS_OP_XOR_LIT |=> ACC_O == (a_q ^ k_q)
    && FLAGS_O.zero == (ACC_O == 8'h00) && $stable(FLAGS_O[2:1])) else $error("xor lit");
  swap_acc_a: assert property (op == SXS_OP_NIB_SWAP && !d
    |=> ACC_O == {k_q[3:0], k_q[7:4]} && $stable(FLAGS_O)) else $error("swap");
endmodule
bind sxs_alu sxs_alu_properties sxs_alu_properties_i (.MCLK_I, .RESET_N_I, .REQ_I, .ACC_O,
  .FLAGS_O, .FILE_WR_O, .DIR_O);

//--- dv/sxs_mem_model.sv
// Purpose: decoder and data file in front of sxs_alu
// Assumes: cell i starts as i times 37
// Notes:   file values reach the operand at once
`timescale 1ns/100ps
module sxs_mem_model
(
  input  wire logic                  clk_i,
  input  wire sxs_alu_pkg::sxs_req_t req_i,
  input  wire sxs_alu_pkg::sxs_fwr_t wr_i,
  output sxs_alu_pkg::sxs_req_t      req_o
);
  import sxs_alu_pkg::*;
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  always @(posedge clk_i) if (wr_i.we) mem[wr_i.addr] <= wr_i.data;
  always_comb
  begin
    req_o = req_i;
    if (req_i.op inside {SXS_OP_REG_SUB, SXS_OP_REG_SUBB, SXS_OP_XOR_REG, SXS_OP_NIB_SWAP})
      req_o.operand = mem[req_i.addr];
  end
endmodule

//--- dv/sxs_alu_tb.sv
// Purpose: self-checking bench for sxs_alu
// Assumes: one request every two cycles
// Notes:   expectations from a reference kept here
`timescale 1ns/100ps
module sxs_alu_tb;
  import sxs_alu_pkg::*;
  logic       MCLK_I = 1'b0;
  logic       RESET_N_I = 1'b0;
  sxs_req_t   rq = '0;
  sxs_req_t   REQ_I;
  logic [7:0] ACC_O;
  sxs_flags_t FLAGS_O;
  sxs_fwr_t   FILE_WR_O;
  sxs_dir_t   DIR_O;
  logic [7:0] ea = 8'h00;
  logic [7:0] em [128];
  sxs_flags_t ef = '0;
  sxs_dir_t   ed = '1;
  int         n_errors = 0;
  int         checks = 0;
  always #50 MCLK_I = ~MCLK_I;
  sxs_alu sxs_alu_i (.MCLK_I, .RESET_N_I, .REQ_I, .ACC_O, .FLAGS_O, .FILE_WR_O, .DIR_O);
  sxs_mem_model sxs_mem_model_i (.clk_i(MCLK_I), .req_i(rq), .wr_i(FILE_WR_O), .req_o(REQ_I));
  task automatic cmp(logic [50:0] got, logic [50:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic run(sxs_op_t o, logic d, logic [6:0] a, logic [7:0] k);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] m;
    logic [7:0] r;
    logic       w;
    logic       c;
    w = o inside {SXS_OP_REG_SUB, SXS_OP_REG_SUBB, SXS_OP_XOR_REG, SXS_OP_NIB_SWAP};
    m = w ? em[a] : k;
    c = (o == SXS_OP_REG_SUBB) ? ef.carry : 1'b1;
    s = {1'b0, m} + {1'b0, ~ea} + 9'(c);
    h = {1'b0, m[3:0]} + {1'b0, ~ea[3:0]} + 5'(c);
    r = (o inside {SXS_OP_XOR_LIT, SXS_OP_XOR_REG}) ? m ^ ea : s[7:0];
    if (o == SXS_OP_NIB_SWAP) r = {m[3:0], m[7:4]};
    if (o inside {SXS_OP_LIT_SUB, SXS_OP_REG_SUB, SXS_OP_REG_SUBB}) ef = '{s[8], h[4], r == 0};
    if (o inside {SXS_OP_XOR_LIT, SXS_OP_XOR_REG}) ef.zero = (r == 8'h00);
    if (o == SXS_OP_DIR_LOAD && a inside {[5:7]}) ed[(7 - a) * 8 +: 8] = ea;
    w = w && d;
    if (w) em[a] = r;
    else if (o != SXS_OP_DIR_LOAD) ea = r;
    @(negedge MCLK_I);
    rq = '{1'b1, o, d, a, k};
    @(negedge MCLK_I);
    rq.valid = 1'b0;
    cmp({ACC_O, FLAGS_O, DIR_O, FILE_WR_O.we, w ? FILE_WR_O[14:0] : 15'h0000},
        {ea, ef, ed, w, w ? {a, r} : 15'h0000});
  endtask
  task automatic t_sub();
    run(SXS_OP_LIT_SUB, 1'b0, 7'h00, 8'h05);
    run(SXS_OP_LIT_SUB, 1'b0, 7'h00, 8'h04);
    run(SXS_OP_REG_SUBB, 1'b0, 7'h22, 8'h00);
    run(SXS_OP_LIT_SUB, 1'b0, 7'h00, 8'hff);
    run(SXS_OP_REG_SUBB, 1'b1, 7'h10, 8'h00);
    run(SXS_OP_REG_SUB, 1'b0, 7'h7f, 8'h00);
    run(SXS_OP_REG_SUB, 1'b1, 7'h10, 8'h00);
  endtask
  task automatic t_logic();
    run(SXS_OP_XOR_LIT, 1'b0, 7'h00, 8'hff);
    run(SXS_OP_XOR_LIT, 1'b0, 7'h00, ea);
    run(SXS_OP_XOR_REG, 1'b0, 7'h03, 8'h00);
    run(SXS_OP_XOR_REG, 1'b1, 7'h04, 8'h00);
    run(SXS_OP_NIB_SWAP, 1'b0, 7'h04, 8'h00);
    run(SXS_OP_NIB_SWAP, 1'b1, 7'h05, 8'h00);
  endtask
  task automatic t_dir();
    for (int i = 4; i < 9; i++)
    begin
      run(SXS_OP_XOR_LIT, 1'b0, 7'h00, 8'(i * 17));
      run(SXS_OP_DIR_LOAD, 1'b0, 7'(i), 8'h00);
    end
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++) em[i] = 8'(i * 37);
    repeat (8) @(negedge MCLK_I);
    RESET_N_I = 1'b1;
    t_sub();
    t_logic();
    t_dir();
    stop_test();
  end
  initial
  begin
    // about 50 cycles of work; 2000 cycles is ample
    #200000;
    n_errors++;
    stop_test();
  end
endmodule
